// *** src/mac_dma_status_summary.sv ***
`timescale 1ns/1ns
// How it works
// - Bits 22 to 20 of dma_status show the transmit process state, read-only.
// - Transmit running codes: 001 fetch, 010 wait end, 011 move buffer, 101 setup, 111 close.
// - Transmit shows 000 when stopped, 110 when suspended, and never the reserved 100.
// - Bits 19 to 17 of dma_status show the receive process state, read-only.
// - Receive running codes: 001 fetch, 010 wait end, 011 wait packet, 101 close, 111 move.
// - Receive shows 000 when stopped, 100 when suspended, and never the reserved 110.
// - Bit 16 is the OR of the flags at bits 0, 2, 6, 11 and 14.
// - Bit 15 is the OR of the flags at bits 1, 5, 7, 8 and 10.
// - A masked flag may still set but feeds neither summary.
// - Every event flag clears on a written one, and each summary once its unmasked flags are clear; a zero does nothing.
// - Bit 14 sets once the buffers of a frame's first descriptor are filled.
// - Unimplemented bits read a fixed value and ignore writes.
module mac_dma_status_summary
  import mac_status_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_in,
  input wire logic [2:0] tx_proc_state_in,
  input wire logic [2:0] rx_proc_state_in,
  input wire dma_events_type dma_events_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_out
);

  // ---- Bus slave state ----
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [STRB_W-1:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [DATA_W-1:0] rdata_ff;

  // ---- Block state ----
  tx_proc_state_type tx_proc_state_ff;
  rx_proc_state_type rx_proc_state_ff;
  logic [31:0] dma_mask_ff;
  logic [31:0] flags;
  logic [31:0] event_set;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] status_word;
  logic normal_irq_summary;
  logic abnormal_irq_summary;

  // ---- Decode ----
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic [31:0] wr_bits;
  logic wr_status;
  logic wr_mask;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;

  // Register select on the word address; the low two bits never matter
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] offs);
    return addr[ADDR_W-1:2] == offs[ADDR_W-1:2];
  endfunction

  // Write address channel: one write at a time, held until the response is taken
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign aw_hs = s_axi_awvalid && s_axi_awready;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (aw_hs) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  // Write data channel, taken independently of the address
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign w_hs = s_axi_wvalid && s_axi_wready;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      w_held_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (w_hs) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // The write acts in the cycle after both halves are held
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_status = wr_fire && addr_is(awaddr_ff, DMA_STATUS_OFFSET);
  assign wr_mask = wr_fire && addr_is(awaddr_ff, DMA_MASK_OFFSET);
  assign wr_hit = wr_status || wr_mask;
  assign wr_bits = wdata_ff & strb_expand(wstrb_ff);

  // Write response; unmapped offsets answer SLVERR and change nothing
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= AXI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Read channel: the word is sampled at the address handshake
  assign s_axi_arready = !rvalid_ff;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign rd_hit = addr_is(s_axi_araddr, DMA_STATUS_OFFSET)
               || addr_is(s_axi_araddr, DMA_MASK_OFFSET);

  // Read data mux; misses read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (addr_is(s_axi_araddr, DMA_STATUS_OFFSET)) begin
      rd_word = status_word;
    end else if (addr_is(s_axi_araddr, DMA_MASK_OFFSET)) begin
      rd_word = dma_mask_ff;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= AXI_RESP_OKAY;
      rdata_ff <= '0;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
      rdata_ff <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // Transmit state field follows the engine; the reserved code is never shown
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_proc_state_ff <= TX_STOPPED;
    end else if (soft_reset_in) begin
      tx_proc_state_ff <= TX_STOPPED;
    end else begin
      unique case (tx_proc_state_in)
        TX_STOPPED: tx_proc_state_ff <= TX_STOPPED;
        TX_FETCH_DESC: tx_proc_state_ff <= TX_FETCH_DESC;
        TX_WAIT_END: tx_proc_state_ff <= TX_WAIT_END;
        TX_MOVE_BUF: tx_proc_state_ff <= TX_MOVE_BUF;
        TX_SETUP_PKT: tx_proc_state_ff <= TX_SETUP_PKT;
        TX_SUSPENDED: tx_proc_state_ff <= TX_SUSPENDED;
        TX_CLOSE_DESC: tx_proc_state_ff <= TX_CLOSE_DESC;
        default: tx_proc_state_ff <= tx_proc_state_ff;
      endcase
    end
  end

  // Receive state field, same treatment; a stray reserved code holds the last one
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_proc_state_ff <= RX_STOPPED;
    end else if (soft_reset_in) begin
      rx_proc_state_ff <= RX_STOPPED;
    end else begin
      unique case (rx_proc_state_in)
        RX_STOPPED: rx_proc_state_ff <= RX_STOPPED;
        RX_FETCH_DESC: rx_proc_state_ff <= RX_FETCH_DESC;
        RX_WAIT_END: rx_proc_state_ff <= RX_WAIT_END;
        RX_WAIT_PKT: rx_proc_state_ff <= RX_WAIT_PKT;
        RX_SUSPENDED: rx_proc_state_ff <= RX_SUSPENDED;
        RX_CLOSE_DESC: rx_proc_state_ff <= RX_CLOSE_DESC;
        RX_MOVE_DATA: rx_proc_state_ff <= RX_MOVE_DATA;
        default: rx_proc_state_ff <= rx_proc_state_ff;
      endcase
    end
  end

  // Mask register: only event positions are writable
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_mask_ff <= DMA_MASK_RESET;
    end else if (soft_reset_in) begin
      dma_mask_ff <= DMA_MASK_RESET;
    end else if (wr_mask) begin
      dma_mask_ff <= ((dma_mask_ff & ~strb_expand(wstrb_ff))
                     | wr_bits) & EVENT_BITS;
    end
  end

  // Event pulses placed at their status positions
  always_comb begin
    event_set = 32'h0000_0000;
    event_set[TX_DONE_BIT] = dma_events_in.tx_done_event;
    event_set[TX_STOPPED_BIT] = dma_events_in.tx_stopped_flag;
    event_set[TX_BUF_UNAVAIL_BIT] = dma_events_in.tx_buf_unavail;
    event_set[TX_UNDERFLOW_BIT] = dma_events_in.tx_underflow_flag;
    event_set[RX_DONE_BIT] = dma_events_in.rx_done_event;
    event_set[RX_BUF_UNAVAIL_BIT] = dma_events_in.rx_buf_unavail;
    event_set[RX_STOPPED_BIT] = dma_events_in.rx_stopped_flag;
    event_set[EARLY_TX_BIT] = dma_events_in.early_tx_event;
    event_set[GP_TIMER_BIT] = dma_events_in.gp_timer_expired;
    event_set[EARLY_RX_BIT] = dma_events_in.early_rx_event;
  end

  // Summaries gather only unmasked flags; masked ones still set above
  assign normal_irq_summary = |(flags & dma_mask_ff & NORMAL_GROUP);
  assign abnormal_irq_summary = |(flags & dma_mask_ff & ABNORMAL_GROUP);

  // Summary bits re-set each cycle an unmasked flag remains, so a clear
  // only sticks once the flags behind it are cleared too
  always_comb begin
    set_vec = event_set;
    set_vec[NORMAL_SUM_BIT] = normal_irq_summary;
    set_vec[ABNORMAL_SUM_BIT] = abnormal_irq_summary;
  end

  // Write-one-to-clear on sticky positions only; state and gaps ignore writes
  assign clr_vec = wr_status ? (wr_bits & STICKY_BITS) : 32'h0000_0000;

  sticky_flag_bank #(
    .WIDTH(32),
    .IMPL(STICKY_BITS)
  ) u_flags (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sync_clr_in(soft_reset_in),
    .set_in(set_vec),
    .clr_in(clr_vec),
    .flags_out(flags)
  );

  // Status word as read by software
  always_comb begin
    status_word = (flags & STICKY_BITS) | (UNIMPL_READ_VALUE & UNIMPL_BITS);
    status_word[TX_STATE_LSB +: STATE_W] = tx_proc_state_ff;
    status_word[RX_STATE_LSB +: STATE_W] = rx_proc_state_ff;
  end

  // One level interrupt from the registered summaries
  assign irq_out = flags[NORMAL_SUM_BIT] || flags[ABNORMAL_SUM_BIT];

endmodule // mac_dma_status_summary

// *** src/mac_status_pkg.sv ***
package mac_status_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Register byte offsets
  localparam logic [7:0] DMA_STATUS_OFFSET = 8'h00;
  localparam logic [7:0] DMA_MASK_OFFSET = 8'h04;

  // Event flag, summary and state field positions in dma_status
  localparam int TX_DONE_BIT = 0;
  localparam int TX_STOPPED_BIT = 1;
  localparam int TX_BUF_UNAVAIL_BIT = 2;
  localparam int TX_UNDERFLOW_BIT = 5;
  localparam int RX_DONE_BIT = 6;
  localparam int RX_BUF_UNAVAIL_BIT = 7;
  localparam int RX_STOPPED_BIT = 8;
  localparam int EARLY_TX_BIT = 10;
  localparam int GP_TIMER_BIT = 11;
  localparam int EARLY_RX_BIT = 14;
  localparam int ABNORMAL_SUM_BIT = 15;
  localparam int NORMAL_SUM_BIT = 16;
  localparam int RX_STATE_LSB = 17;
  localparam int TX_STATE_LSB = 20;
  localparam int STATE_W = 3;

  // Bit groups of dma_status
  localparam logic [31:0] NORMAL_GROUP = 32'h0000_4845;
  localparam logic [31:0] ABNORMAL_GROUP = 32'h0000_05a2;
  localparam logic [31:0] EVENT_BITS = 32'h0000_4de7;
  localparam logic [31:0] STICKY_BITS = 32'h0001_cde7;
  localparam logic [31:0] STATE_BITS = 32'h007e_0000;
  localparam logic [31:0] UNIMPL_BITS = 32'hff80_3218;

  // Reset and fixed values
  localparam logic [31:0] DMA_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] DMA_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] UNIMPL_READ_VALUE = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
  localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TX_STOPPED = 3'b000,
    TX_FETCH_DESC = 3'b001,
    TX_WAIT_END = 3'b010,
    TX_MOVE_BUF = 3'b011,
    TX_RESERVED = 3'b100,
    TX_SETUP_PKT = 3'b101,
    TX_SUSPENDED = 3'b110,
    TX_CLOSE_DESC = 3'b111
  } tx_proc_state_type;

  typedef enum logic [2:0] {
    RX_STOPPED = 3'b000,
    RX_FETCH_DESC = 3'b001,
    RX_WAIT_END = 3'b010,
    RX_WAIT_PKT = 3'b011,
    RX_SUSPENDED = 3'b100,
    RX_CLOSE_DESC = 3'b101,
    RX_RESERVED = 3'b110,
    RX_MOVE_DATA = 3'b111
  } rx_proc_state_type;

  // One-cycle event pulses from the DMA engines
  typedef struct packed {
    logic early_rx_event;
    logic gp_timer_expired;
    logic early_tx_event;
    logic rx_stopped_flag;
    logic rx_buf_unavail;
    logic rx_done_event;
    logic tx_underflow_flag;
    logic tx_buf_unavail;
    logic tx_stopped_flag;
    logic tx_done_event;
  } dma_events_type;

  // Byte strobes to a bit mask
  function automatic logic [31:0] strb_expand(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

endpackage

// *** src/sticky_flag_bank.sv ***
`timescale 1ns/1ns
// Bank of sticky flags: hardware sets, software clears, set wins
module sticky_flag_bank
  import mac_status_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] IMPL = '1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sync_clr_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  output logic [WIDTH-1:0] flags_out
);

  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;

  // A set in the clearing cycle survives the clear
  assign nxt_flags = ((flags_ff & ~clr_in) | set_in) & IMPL;

  // Flag storage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_ff <= '0;
    end else if (sync_clr_in) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_out = flags_ff;

endmodule // sticky_flag_bank

// *** sim/dma_status_checker.sv ***
`timescale 1ns/1ns
// Bus handshake and interrupt timing seen at the block's pins
module dma_status_checker
  import mac_status_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_in,
  input wire dma_events_type dma_events_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Address and data of one write taken at the same edge
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write answer not on time");
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer not on time");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // The slave decodes word addresses, so the two low address bits are ignored here too
  unmapped_read_a: assert property (ar_taken ##0
      (s_axi_araddr[ADDR_W-1:2] != DMA_STATUS_OFFSET[ADDR_W-1:2] &&
      s_axi_araddr[ADDR_W-1:2] != DMA_MASK_OFFSET[ADDR_W-1:2])
      |=> s_axi_rresp == AXI_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered wrongly");
  soft_quiet_a: assert property (soft_reset_in [*2] |=> !irq_out)
    else $error("interrupt after soft clear");
  irq_cause_a: assert property ($rose(irq_out) |-> $past(|dma_events_in, 2) || $past(s_axi_bvalid))
    else $error("interrupt without cause");
endmodule // dma_status_checker

bind mac_dma_status_summary dma_status_checker checker_inst (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .soft_reset_in(soft_reset_in), .dma_events_in(dma_events_in),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_out(irq_out));

// *** sim/dma_host_model.sv ***
`timescale 1ns/1ns
// Host processor: one write and one read at a time on the register bus
module dma_host_model
  import mac_status_pkg::*;
(
  input wire logic clk_in,
  output logic [ADDR_W-1:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [DATA_W-1:0] wdata_out,
  output logic [STRB_W-1:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [ADDR_W-1:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  // Cycles before bready or rready rise; above one the slave must hold a read answer, above two a write answer
  int ready_lag = 0;
  // Idle bus from time zero
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out} = '0;
    {bready_out, araddr_out, arvalid_out, rready_out} = '0;
  end
  // Ones written to flags clear them; handshakes judged from pre-edge levels
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta;
    logic tw;
    logic got_b;
    int n;
    n = 0;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= (ready_lag == 0);
    do begin
      @(negedge clk_in);
      ta = awvalid_out && awready_in;
      tw = wvalid_out && wready_in;
      got_b = bvalid_in && bready_out;
      @(posedge clk_in);
      n++;
      if (ta) awvalid_out <= 1'b0;
      if (tw) wvalid_out <= 1'b0;
      if (!got_b && n >= ready_lag) bready_out <= 1'b1;
    end while (!got_b);
    bready_out <= 1'b0;
  endtask
  // Read one word; the bench monitor collects the data
  task automatic rd(input logic [7:0] a);
    logic ta;
    logic got;
    int n;
    n = 0;
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= (ready_lag == 0);
    do begin
      @(negedge clk_in);
      ta = arvalid_out && arready_in;
      got = rvalid_in && rready_out;
      @(posedge clk_in);
      n++;
      if (ta) arvalid_out <= 1'b0;
      if (!got && n >= ready_lag) rready_out <= 1'b1;
    end while (!got);
    rready_out <= 1'b0;
  endtask
endmodule // dma_host_model

// *** sim/tb.sv ***
`timescale 1ns/1ns
// Self-checking bench for the status and summary block
module tb;
  import mac_status_pkg::*;
  logic clk_in, rst_n_in, soft_reset_in, irq_out;
  logic [2:0] tx_st, rx_st, tx_exp, rx_exp;
  dma_events_type ev;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, flags, mask;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors = 0;
  int n_checks = 0;
  int ebit[10] = '{0, 1, 2, 5, 6, 7, 8, 10, 11, 14};
  logic [34:0] rd_q[$];
  logic [1:0] wr_q[$];
  mac_dma_status_summary mac_dma_status_summary_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .soft_reset_in(soft_reset_in), .tx_proc_state_in(tx_st), .rx_proc_state_in(rx_st),
    .dma_events_in(ev), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq_out(irq_out));
  dma_host_model dma_host_model_inst (.clk_in(clk_in), .awaddr_out(s_axi_awaddr),
    .awvalid_out(s_axi_awvalid), .awready_in(s_axi_awready), .wdata_out(s_axi_wdata),
    .wstrb_out(s_axi_wstrb), .wvalid_out(s_axi_wvalid), .wready_in(s_axi_wready),
    .bvalid_in(s_axi_bvalid), .bready_out(s_axi_bready), .araddr_out(s_axi_araddr),
    .arvalid_out(s_axi_arvalid), .arready_in(s_axi_arready), .rvalid_in(s_axi_rvalid),
    .rready_out(s_axi_rready));
  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Read answer: response, interrupt level and data word
  task automatic chk_rd(input logic [34:0] got, input logic [34:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write answer: response code only
  task automatic chk_wr(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Answers are judged before the edge that takes them, oldest note first
  always @(negedge clk_in) begin
    if (s_axi_rvalid && s_axi_rready) begin
      chk_rd({s_axi_rresp, irq_out, s_axi_rdata}, rd_q.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      chk_wr(s_axi_bresp, wr_q.pop_front());
    end
  end
  // Status word as the bench's own copies predict it
  function automatic logic [34:0] stat();
    logic [31:0] s;
    s = flags;
    s[22:20] = tx_exp;
    s[19:17] = rx_exp;
    return {AXI_RESP_OKAY, s[16] | s[15], s};
  endfunction
  task automatic rexp(input logic [7:0] a, input logic [34:0] e);
    rd_q.push_back(e);
    dma_host_model_inst.rd(a);
  endtask
  task automatic wexp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    wr_q.push_back(r);
    dma_host_model_inst.wr(a, d);
  endtask
  // One-cycle event; summaries follow only through enabled mask bits
  task automatic pulse(input int i);
    @(posedge clk_in);
    ev <= dma_events_type'(10'h1 << i);
    @(posedge clk_in);
    ev <= '0;
    flags[ebit[i]] = 1'b1;
    flags[16] = flags[16] | (|(flags & mask & NORMAL_GROUP));
    flags[15] = flags[15] | (|(flags & mask & ABNORMAL_GROUP));
    repeat (2) @(posedge clk_in);
  endtask
  // Flags first, summaries after: a summary re-sets while its flags stand
  task automatic clear_all();
    wexp(DMA_STATUS_OFFSET, EVENT_BITS, AXI_RESP_OKAY);
    flags = flags & ~EVENT_BITS;
    wexp(DMA_STATUS_OFFSET, 32'h0001_8000, AXI_RESP_OKAY);
    flags = 32'h0;
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'haa22));
    {rst_n_in, soft_reset_in, tx_st, rx_st, tx_exp, rx_exp, flags, mask} = '0;
    ev = '0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rexp(DMA_STATUS_OFFSET, stat());
    rexp(DMA_MASK_OFFSET, {AXI_RESP_OKAY, 1'b0, DMA_MASK_RESET});
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_in);
      tx_st <= 3'(i);
      rx_st <= 3'(7 - i);
      if (i != 4) tx_exp = 3'(i);
      if (i != 1) rx_exp = 3'(7 - i);
      repeat (2) @(posedge clk_in);
      rexp(DMA_STATUS_OFFSET, stat());
    end
    // From here on ready lags each request by 1 to 4 cycles, so read answers must stand above a lag of one, write answers above two
    dma_host_model_inst.ready_lag = 1 + $urandom_range(3);
    wexp(DMA_STATUS_OFFSET, $urandom() & ~STICKY_BITS, AXI_RESP_OKAY);
    rexp(DMA_STATUS_OFFSET, stat());
    wexp(DMA_MASK_OFFSET, EVENT_BITS, AXI_RESP_OKAY);
    mask = EVENT_BITS;
    rexp(DMA_MASK_OFFSET, {AXI_RESP_OKAY, 1'b0, EVENT_BITS});
    for (int i = 0; i < 10; i++) begin
      pulse(i);
      rexp(DMA_STATUS_OFFSET, stat());
      wexp(DMA_STATUS_OFFSET, 32'h0, AXI_RESP_OKAY);
      rexp(DMA_STATUS_OFFSET, stat());
      clear_all();
      rexp(DMA_STATUS_OFFSET, stat());
    end
    wexp(DMA_MASK_OFFSET, 32'h0, AXI_RESP_OKAY);
    mask = 32'h0;
    pulse($urandom_range(9));
    rexp(DMA_STATUS_OFFSET, stat());
    clear_all();
    rexp(8'h08, {AXI_RESP_SLVERR, 1'b0, 32'h0});
    wexp(8'h08, $urandom(), AXI_RESP_SLVERR);
    wexp(DMA_MASK_OFFSET, EVENT_BITS, AXI_RESP_OKAY);
    mask = EVENT_BITS;
    pulse(9);
    @(posedge clk_in);
    tx_st <= 3'b000;
    soft_reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    soft_reset_in <= 1'b0;
    {tx_exp, rx_exp, flags, mask} = '0;
    rexp(DMA_STATUS_OFFSET, stat());
    rexp(DMA_MASK_OFFSET, {AXI_RESP_OKAY, 1'b0, DMA_MASK_RESET});
    repeat (4) @(posedge clk_in);
    close_out();
  end
  // Cuts a hang short well beyond the expected run of a few hundred cycles
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
endmodule // tb
